//--- rtl/fmd_pkg.sv
package fmd_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [7:0] ADDR_CONFIG    = 8'h15;
    localparam logic [7:0] ADDR_SOURCE    = 8'h16;
    localparam logic [7:0] ADDR_THRESHOLD = 8'h17;
    localparam logic [7:0] ADDR_COUNT     = 8'h18;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CFG_LATCH_BIT   = 7;
    localparam int CFG_OR_AND_BIT  = 6;
    localparam int CFG_Z_EN_BIT    = 5;
    localparam int CFG_Y_EN_BIT    = 4;
    localparam int CFG_X_EN_BIT    = 3;
    localparam int SRC_ACTIVE_BIT  = 7;
    localparam int THS_DBMODE_BIT  = 7;

    // ****************************************************************
    // Widths and values after reset
    // ****************************************************************
    localparam int NUM_AXES        = 3;
    localparam int ACC_W           = 12;
    localparam int THR_W           = 7;
    localparam int CNT_W           = 8;
    localparam int MAG_SHIFT       = 4;
    localparam logic [THR_W-1:0] THR_LOW_NOISE_MAX = 7'h40;
    localparam logic [THR_W-1:0] THR_RESET         = 7'h00;
    localparam logic [CNT_W-1:0] COUNT_RESET       = 8'h00;
    localparam logic [2:0]       AXIS_EN_RESET     = 3'h0;
    localparam logic [5:0]       FLAGS_RESET       = 6'h00;
    localparam logic [7:0]       RDATA_RESET       = 8'h00;

    typedef logic signed [ACC_W-1:0] fmd_acc_t;

endpackage : fmd_pkg

//--- rtl/fmd_axis_if.sv
`timescale 1ns/1ns
interface fmd_axis_if;
    fmd_pkg::fmd_acc_t          sample;
    logic                       enable;
    logic [fmd_pkg::THR_W-1:0]  thr;
    logic                       high;
    logic                       low;
    logic                       neg;

    modport cmp (
        input  sample,
        input  enable,
        input  thr,
        output high,
        output low,
        output neg
    );
    modport top (
        output sample,
        output enable,
        output thr,
        input  high,
        input  low,
        input  neg
    );
endinterface : fmd_axis_if

//--- rtl/fmd_axis_cmp.sv
`timescale 1ns/1ns
module fmd_axis_cmp (
    fmd_axis_if.cmp ax
);
    logic [fmd_pkg::ACC_W:0]               mag;
    logic [fmd_pkg::ACC_W-fmd_pkg::MAG_SHIFT:0] mag_thr;

    // ****************************************************************
    // Magnitude on the 8g scale, one count per threshold step
    // ****************************************************************
    always_comb begin
        mag = ax.sample[fmd_pkg::ACC_W-1]
            ? (~{ax.sample[fmd_pkg::ACC_W-1], ax.sample} + 13'h0001)
            : {1'b0, ax.sample};
        mag_thr = mag[fmd_pkg::ACC_W:fmd_pkg::MAG_SHIFT];
        ax.high = ax.enable && (mag_thr > {2'h0, ax.thr});
        ax.low  = !ax.enable || (mag_thr <= {2'h0, ax.thr});
        ax.neg  = ax.sample[fmd_pkg::ACC_W-1];
    end

endmodule : fmd_axis_cmp

//--- rtl/fmd_top.sv
// Operation
// - Latched motion: active stays until source read
// - Latched source read clears bits and counter
// - Idle flags show live per-axis status
// - Latched flags freeze while event active
// - Latch bit: zero live, one latched
// - Select bit: zero AND freefall, one OR
// - Axis enables default off, include axis
// - Freefall: all enabled magnitudes at/below threshold
// - Motion: any enabled magnitude above threshold
// - Seven-bit unsigned threshold, default zero
// - Axis flag one on detected event
// - Polarity one for negative acceleration above threshold
// - Disabled axis flag and polarity zero
// - Active drives routed, enabled interrupt
// - Clear mode zeroes counter when false
// - Default mode decrements counter toward zero
// - Comparison spans 8g at any scale
// - Low noise limits threshold to 4g
// - Event at count; counter saturates there
// - Unlatched clear mode drops active immediately
`timescale 1ns/1ns
module fmd_top (
    input  wire logic                      I_CLOCK,
    input  wire logic                      I_RST_N,
    input  wire logic                      I_SAMPLE_STB,
    input  wire logic [fmd_pkg::ACC_W-1:0] I_ACC_X,
    input  wire logic [fmd_pkg::ACC_W-1:0] I_ACC_Y,
    input  wire logic [fmd_pkg::ACC_W-1:0] I_ACC_Z,
    input  wire logic                      I_LOW_NOISE,
    input  wire logic                      I_INT_EN,
    input  wire logic                      I_INT_ROUTE,
    input  wire logic                      I_REG_WE,
    input  wire logic                      I_REG_RE,
    input  wire logic [7:0]                I_REG_ADDR,
    input  wire logic [7:0]                I_REG_WDATA,
    output logic      [7:0]                O_REG_RDATA,
    output logic                           O_INT1,
    output logic                           O_INT2
);

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic                        latch_en_q,  latch_en_d;
    logic                        or_sel_q,    or_sel_d;
    logic [2:0]                  axis_en_q,   axis_en_d;
    logic                        db_clear_q,  db_clear_d;
    logic [fmd_pkg::THR_W-1:0]   thr_q,       thr_d;
    logic [fmd_pkg::CNT_W-1:0]   count_q,     count_d;

    // ****************************************************************
    // Detector state
    // ****************************************************************
    logic [fmd_pkg::CNT_W-1:0]   cnt_q,       cnt_d;
    logic                        active_q,    active_d;
    logic [5:0]                  flags_q,     flags_d;
    logic [7:0]                  rdata_q,     rdata_d;
    logic                        int1_q,      int1_d;
    logic                        int2_q,      int2_d;

    logic [fmd_pkg::THR_W-1:0]   thr_eff;
    logic [2:0]                  ax_high;
    logic [2:0]                  ax_low;
    logic [2:0]                  ax_neg;
    logic [5:0]                  live_flags;
    logic [5:0]                  en_mask;
    logic                        any_high;
    logic                        all_low;
    logic                        cond;
    logic                        src_read;
    logic                        reached;
    fmd_pkg::fmd_acc_t           acc [fmd_pkg::NUM_AXES];

    assign acc[0] = I_ACC_X;
    assign acc[1] = I_ACC_Y;
    assign acc[2] = I_ACC_Z;

    // ****************************************************************
    // Per-axis comparators
    // ****************************************************************
    always_comb begin
        thr_eff = (I_LOW_NOISE && (thr_q > fmd_pkg::THR_LOW_NOISE_MAX))
                ? fmd_pkg::THR_LOW_NOISE_MAX : thr_q;
    end

    fmd_axis_if ax_if [fmd_pkg::NUM_AXES] ();

    for (genvar i = 0; i < fmd_pkg::NUM_AXES; i++) begin : g_axis
        assign ax_if[i].sample = acc[i];
        assign ax_if[i].enable = axis_en_q[i];
        assign ax_if[i].thr    = thr_eff;
        assign ax_high[i]      = ax_if[i].high;
        assign ax_low[i]       = ax_if[i].low;
        assign ax_neg[i]       = ax_if[i].neg;
        assign live_flags[2*i+1] = ax_if[i].high;
        assign live_flags[2*i]   = ax_high[i] & ax_neg[i];
        assign en_mask[2*i+1]    = axis_en_q[i];
        assign en_mask[2*i]      = axis_en_q[i];
        fmd_axis_cmp u_cmp (
            .ax (ax_if[i])
        );
    end

    // ****************************************************************
    // Combined condition
    // ****************************************************************
    always_comb begin
        any_high = |ax_high;
        all_low  = &ax_low;
        cond     = (|axis_en_q) && (or_sel_q ? any_high : all_low);
        src_read = I_REG_RE && (I_REG_ADDR == fmd_pkg::ADDR_SOURCE);
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always_comb begin
        latch_en_d = latch_en_q;
        or_sel_d   = or_sel_q;
        axis_en_d  = axis_en_q;
        db_clear_d = db_clear_q;
        thr_d      = thr_q;
        count_d    = count_q;
        if (I_REG_WE) begin
            case (I_REG_ADDR)
                fmd_pkg::ADDR_CONFIG: begin
                    latch_en_d = I_REG_WDATA[fmd_pkg::CFG_LATCH_BIT];
                    or_sel_d   = I_REG_WDATA[fmd_pkg::CFG_OR_AND_BIT];
                    axis_en_d  = {I_REG_WDATA[fmd_pkg::CFG_Z_EN_BIT],
                                  I_REG_WDATA[fmd_pkg::CFG_Y_EN_BIT],
                                  I_REG_WDATA[fmd_pkg::CFG_X_EN_BIT]};
                end
                fmd_pkg::ADDR_THRESHOLD: begin
                    db_clear_d = I_REG_WDATA[fmd_pkg::THS_DBMODE_BIT];
                    thr_d      = I_REG_WDATA[fmd_pkg::THR_W-1:0];
                end
                fmd_pkg::ADDR_COUNT: begin
                    count_d    = I_REG_WDATA;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            latch_en_q <= 1'b0;
            or_sel_q   <= 1'b0;
            axis_en_q  <= fmd_pkg::AXIS_EN_RESET;
            db_clear_q <= 1'b0;
            thr_q      <= fmd_pkg::THR_RESET;
            count_q    <= fmd_pkg::COUNT_RESET;
        end else begin
            latch_en_q <= latch_en_d;
            or_sel_q   <= or_sel_d;
            axis_en_q  <= axis_en_d;
            db_clear_q <= db_clear_d;
            thr_q      <= thr_d;
            count_q    <= count_d;
        end
    end

    // ****************************************************************
    // Debounce counter, event flag and source bits
    // ****************************************************************
    always_comb begin
        cnt_d    = cnt_q;
        active_d = active_q;
        flags_d  = flags_q;
        reached  = 1'b0;
        if (cnt_d > count_q) begin
            cnt_d = count_q;
        end
        if (src_read && latch_en_q) begin
            cnt_d    = fmd_pkg::COUNT_RESET;
            active_d = 1'b0;
            flags_d  = fmd_pkg::FLAGS_RESET;
        end
        if (I_SAMPLE_STB) begin
            if (cond) begin
                if (cnt_d != count_q) begin
                    cnt_d = cnt_d + 8'h01;
                end
            end else if (db_clear_q) begin
                cnt_d = fmd_pkg::COUNT_RESET;
            end else if (cnt_d != 8'h00) begin
                cnt_d = cnt_d - 8'h01;
            end
            reached = cond && (cnt_d == count_q);
            if (!(latch_en_q && active_d)) begin
                flags_d = live_flags;
            end
            if (reached) begin
                active_d = 1'b1;
            end else if (!latch_en_q && (db_clear_q || (cnt_d == 8'h00))) begin
                active_d = 1'b0;
            end
        end
    end

    // ****************************************************************
    // Read path and interrupt lines
    // ****************************************************************
    always_comb begin
        rdata_d = rdata_q;
        if (I_REG_RE) begin
            case (I_REG_ADDR)
                fmd_pkg::ADDR_CONFIG:    rdata_d = {latch_en_q, or_sel_q, axis_en_q, 3'h0};
                fmd_pkg::ADDR_SOURCE:    rdata_d = {active_q, 1'b0, flags_q & en_mask};
                fmd_pkg::ADDR_THRESHOLD: rdata_d = {db_clear_q, thr_q};
                fmd_pkg::ADDR_COUNT:     rdata_d = count_q;
                default:                 rdata_d = fmd_pkg::RDATA_RESET;
            endcase
        end
        int1_d = active_q && I_INT_EN && I_INT_ROUTE;
        int2_d = active_q && I_INT_EN && !I_INT_ROUTE;
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            cnt_q    <= fmd_pkg::COUNT_RESET;
            active_q <= 1'b0;
            flags_q  <= fmd_pkg::FLAGS_RESET;
            rdata_q  <= fmd_pkg::RDATA_RESET;
            int1_q   <= 1'b0;
            int2_q   <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            active_q <= active_d;
            flags_q  <= flags_d;
            rdata_q  <= rdata_d;
            int1_q   <= int1_d;
            int2_q   <= int2_d;
        end
    end

    assign O_REG_RDATA = rdata_q;
    assign O_INT1      = int1_q;
    assign O_INT2      = int2_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_N);

    a_cnt_saturates: assert property (I_SAMPLE_STB |=> cnt_q <= $past(count_q))
        else $error("debounce counter passed programmed count");

    a_cnt_increments: assert property (
        I_SAMPLE_STB && cond && !src_read && (cnt_q < count_q) |=> cnt_q == $past(cnt_q) + 8'h01)
        else $error("debounce counter did not increment");

    a_cnt_clears: assert property (I_SAMPLE_STB && !cond && db_clear_q |=> cnt_q == 8'h00)
        else $error("debounce counter not cleared in clear mode");

    a_cnt_decrements: assert property (
        I_SAMPLE_STB && !cond && !db_clear_q && !src_read && (cnt_q != 8'h00) && (cnt_q <= count_q)
        |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("debounce counter did not decrement");

    a_latch_holds: assert property (
        latch_en_q && active_q && !src_read && !I_REG_WE |=> active_q && $stable(flags_q))
        else $error("latched event changed before source read");

    a_read_clears: assert property (
        src_read && latch_en_q && !I_SAMPLE_STB |=> !active_q && flags_q == 6'h00 && cnt_q == 8'h00)
        else $error("source read did not clear latched state");

    a_masked_zero: assert property (
        src_read |=> (O_REG_RDATA[5:0] & ~$past(en_mask)) == 6'h00 && !O_REG_RDATA[6])
        else $error("disabled axis bits not zero on read");

    a_live_flags: assert property (I_SAMPLE_STB && !active_q |=> flags_q == $past(live_flags))
        else $error("idle flags do not follow live status");

    a_unlatched_drop: assert property (
        I_SAMPLE_STB && !latch_en_q && db_clear_q && !cond |=> !active_q)
        else $error("event active held after condition dropped");

    a_motion_fires: assert property (
        I_SAMPLE_STB && or_sel_q && any_high && (count_q == 8'h00)
        |=> active_q ##1 (O_INT1 == ($past(I_INT_EN) && $past(I_INT_ROUTE)))
            && (O_INT2 == ($past(I_INT_EN) && !$past(I_INT_ROUTE))))
        else $error("motion event or interrupt missing");

    a_freefall_fires: assert property (
        I_SAMPLE_STB && !or_sel_q && (|axis_en_q) && all_low && (count_q == 8'h00) |=> active_q)
        else $error("freefall event missing");

    a_int_follows: assert property (
        O_INT1 == ($past(active_q) && $past(I_INT_EN) && $past(I_INT_ROUTE))
        && O_INT2 == ($past(active_q) && $past(I_INT_EN) && !$past(I_INT_ROUTE)))
        else $error("interrupt line does not follow event active");

    a_unlatched_read: assert property (
        src_read && !latch_en_q && !I_SAMPLE_STB && (cnt_q <= count_q)
        |=> $stable(active_q) && $stable(cnt_q) && $stable(flags_q))
        else $error("unlatched source read changed detector state");

    a_decrement_hold: assert property (
        I_SAMPLE_STB && !latch_en_q && !db_clear_q && !cond && (cnt_q > 8'h01) && (cnt_q <= count_q)
        |=> active_q == $past(active_q))
        else $error("event active dropped before counter emptied");

endmodule : fmd_top

//--- verification/fmd_tb_top.sv
`timescale 1ns/1ns
module fmd_tb_top;

    // ****************************************************************
    // Stimulus signals and device
    // ****************************************************************
    logic        clk        = 1'b0;
    logic        rst_n      = 1'b0;
    logic        stb        = 1'b0;
    logic [11:0] ax         = 12'h000;
    logic [11:0] ay         = 12'h000;
    logic [11:0] az         = 12'h000;
    logic        low_noise  = 1'b0;
    logic        int_en     = 1'b0;
    logic        int_route  = 1'b0;
    logic        we         = 1'b0;
    logic        re         = 1'b0;
    logic [7:0]  addr       = 8'h00;
    logic [7:0]  wdata      = 8'h00;
    logic [7:0]  rdata;
    logic        int1;
    logic        int2;
    logic [31:0] seed       = 32'h4B60;
    int          errors     = 0;
    int          comparisons = 0;

    always #50 clk = ~clk;

    fmd_top u_dut (
        .I_CLOCK     (clk),
        .I_RST_N     (rst_n),
        .I_SAMPLE_STB(stb),
        .I_ACC_X     (ax),
        .I_ACC_Y     (ay),
        .I_ACC_Z     (az),
        .I_LOW_NOISE (low_noise),
        .I_INT_EN    (int_en),
        .I_INT_ROUTE (int_route),
        .I_REG_WE    (we),
        .I_REG_RE    (re),
        .I_REG_ADDR  (addr),
        .I_REG_WDATA (wdata),
        .O_REG_RDATA (rdata),
        .O_INT1      (int1),
        .O_INT2      (int2)
    );

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic stop_test;
        $display("Comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    function automatic logic [31:0] nxt();
        repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction : nxt

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        we = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clk);
        we = 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        re = 1'b1;
        addr = a;
        @(negedge clk);
        re = 1'b0;
        chk("register", rdata, e);
    endtask : rchk

    task automatic smp(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        @(negedge clk);
        stb = 1'b1;
        ax = x;
        ay = y;
        az = z;
        @(negedge clk);
        stb = 1'b0;
    endtask : smp

    function automatic logic [7:0] exp_src(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z,
                                           input logic [7:0] cfg, input logic [6:0] thr, input logic ln);
        logic [11:0] a [3];
        logic [2:0]  hi;
        logic [2:0]  lo;
        logic [2:0]  en;
        logic [6:0]  te;
        logic [11:0] m;
        logic        cond;
        a[0] = x;
        a[1] = y;
        a[2] = z;
        en = cfg[5:3];
        te = (ln && thr > 7'h40) ? 7'h40 : thr;
        for (int i = 0; i < 3; i++) begin
            m = a[i][11] ? (12'h000 - a[i]) : a[i];
            hi[i] = en[i] && (m[11:4] > {1'b0, te});
            lo[i] = en[i] && (m[11:4] <= {1'b0, te});
        end
        cond = cfg[6] ? (|hi) : ((|en) && ((lo | ~en) == 3'h7));
        return {cond, 1'b0, hi[2], hi[2] & z[11], hi[1], hi[1] & y[11], hi[0], hi[0] & x[11]};
    endfunction : exp_src

    initial begin
        #2000000;
        errors++;
        stop_test();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [31:0] r;
        logic [7:0]  cfg;
        logic [6:0]  thr;
        logic [11:0] x;
        logic [7:0]  e;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        rchk(fmd_pkg::ADDR_CONFIG, 8'h00);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h00);
        rchk(fmd_pkg::ADDR_THRESHOLD, 8'h00);
        rchk(fmd_pkg::ADDR_COUNT, 8'h00);
        wr(fmd_pkg::ADDR_CONFIG, 8'hFF);
        rchk(fmd_pkg::ADDR_CONFIG, 8'hF8);
        wr(fmd_pkg::ADDR_SOURCE, 8'hFF);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h00);
        rchk(8'h20, 8'h00);
        wr(fmd_pkg::ADDR_THRESHOLD, 8'hFF);
        rchk(fmd_pkg::ADDR_THRESHOLD, 8'hFF);
        int_en = 1'b1;
        int_route = 1'b1;
        // Decrement mode, count 3, motion on X
        wr(fmd_pkg::ADDR_CONFIG, 8'h48);
        wr(fmd_pkg::ADDR_THRESHOLD, 8'h0A);
        wr(fmd_pkg::ADDR_COUNT, 8'h03);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h020, 12'h000, 12'h000);
        smp(12'h0C8, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h02);
        smp(12'h0C8, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h82);
        chk("int1", {7'h00, int1}, 8'h01);
        chk("int2", {7'h00, int2}, 8'h00);
        repeat (3) smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h020, 12'h000, 12'h000);
        smp(12'h020, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h80);
        smp(12'h020, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h00);
        // Clear mode
        wr(fmd_pkg::ADDR_THRESHOLD, 8'h8A);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h020, 12'h000, 12'h000);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h0C8, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h02);
        smp(12'h0C8, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h82);
        smp(12'h020, 12'h000, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h00);
        // Latched motion on X and Y, count 2
        wr(fmd_pkg::ADDR_CONFIG, 8'hD8);
        wr(fmd_pkg::ADDR_THRESHOLD, 8'h0A);
        wr(fmd_pkg::ADDR_COUNT, 8'h02);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h0C8, 12'h000, 12'h000);
        smp(12'h020, 12'hED4, 12'h000);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h82);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h00);
        smp(12'h000, 12'hED4, 12'h000);
        @(negedge clk);
        chk("int1", {7'h00, int1}, 8'h00);
        smp(12'h000, 12'hED4, 12'h000);
        @(negedge clk);
        chk("int1", {7'h00, int1}, 8'h01);
        rchk(fmd_pkg::ADDR_SOURCE, 8'h8C);
        // Random live traffic, count 0, clear mode
        cfg = 8'h00;
        thr = 7'h00;
        for (int i = 0; i < 64; i++) begin
            r = nxt();
            if (i % 8 == 0) begin
                cfg = {1'b0, r[0], r[3:1], 3'h0};
                thr = (i == 8) ? 7'h7F : r[10:4];
                wr(fmd_pkg::ADDR_CONFIG, cfg);
                wr(fmd_pkg::ADDR_THRESHOLD, {1'b1, thr});
                wr(fmd_pkg::ADDR_COUNT, 8'h00);
                rchk(fmd_pkg::ADDR_CONFIG, cfg);
                r = nxt();
            end
            low_noise = r[11];
            int_en = r[12];
            int_route = r[13];
            x = r[31:20];
            if (i % 8 == 1) x = {1'b0, (low_noise && thr > 7'h40) ? 7'h40 : thr, 4'hF};
            if (i % 8 == 2) x = 12'h800;
            e = exp_src(x, r[19:8], {r[7:0], r[31:28]}, cfg, thr, low_noise);
            smp(x, r[19:8], {r[7:0], r[31:28]});
            rchk(fmd_pkg::ADDR_SOURCE, e);
            chk("int1", {7'h00, int1}, {7'h00, e[7] & int_en & int_route});
            chk("int2", {7'h00, int2}, {7'h00, e[7] & int_en & ~int_route});
        end
        stop_test();
    end

endmodule : fmd_tb_top
